/* rtl/apf_regs.vh */
`ifndef APF_REGS_VH
`define APF_REGS_VH
// ************************************************************
// constants of the power-fail compare controller
// ************************************************************
// operation mode field encodings
`define APF_MODE_CONT_SEL 2'h0
`define APF_MODE_CONT_SCAN 2'h1
`define APF_MODE_ONE_SEL 2'h2
`define APF_MODE_ONE_SCAN 2'h3
// result width and channel select width
`define APF_RES_W 10
`define APF_CH_W 5
// compared high part of the selected channel result, or of channel 0 in scan modes
`define APF_HIGH_W 8
`define APF_HIGH_LSB 2
// condition bit encodings
`define APF_COND_EQ 1'h0
`define APF_COND_LT 1'h1
`endif

/* rtl/apf_compare.v */
// Notes on behaviour
// - compare disabled: interrupt after every conversion
// - compare enabled: interrupt only when condition holds
// - condition zero: interrupt when result equals threshold
// - condition one: interrupt when result below threshold
// - continuous select stores result, gates interrupt
// - continuous select restarts while enable set
// - scan modes compare channel zero high part
// - scan stores channel zero always, then rest
// - continuous scan wraps to channel zero
// - one-shot select converts once then halts
// - one-shot scan stops after one pass
// - select register write keeps interrupt flag
// - config writes may spoil results; restart
// - trigger acknowledge may spoil results
// - each conversion yields ten-bit result
// - two-bit field selects four operation modes
// - setting enable starts conversion of selection
`timescale 1ns/1ps
`include "apf_regs.vh"

module apf_compare #(
    parameter RES_W = `APF_RES_W,
    parameter CH_W = `APF_CH_W
) (
    input wire sys_clk,
    input wire srst,
    input wire converter_enable_bit,
    input wire converter_power_bit,
    input wire [1:0] operation_mode_field,
    input wire [CH_W-1:0] channel_select_reg,
    input wire compare_enable_bit,
    input wire compare_condition_bit,
    input wire [`APF_HIGH_W-1:0] compare_threshold_reg,
    input wire config_write,
    input wire flag_clear,
    input wire conv_done,
    input wire [RES_W-1:0] conv_data,
    output reg conv_start,
    output reg [CH_W-1:0] conv_channel,
    output reg busy,
    output reg result_we,
    output reg [CH_W-1:0] result_channel,
    output reg [RES_W-1:0] channel_result_reg,
    output reg [RES_W-1:0] channel0_result_reg,
    output reg conv_end_irq,
    output reg conv_end_irq_flag
);

    // ************************************************************
    // states
    // ************************************************************
    localparam ST_IDLE = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_WAIT = 2'h2;
    localparam ST_HALT = 2'h3;

    // sequencer state and next values
    reg [1:0] state;
    reg [1:0] next_state;
    reg [CH_W-1:0] next_channel;
    // two-stage synchronisers and edge detector
    reg en_sync1;
    reg en_sync2;
    reg pwr_sync1;
    reg pwr_sync2;
    reg done_sync1;
    reg done_sync2;
    reg done_prev;
    reg [RES_W-1:0] data_sync1;
    reg [RES_W-1:0] data_sync2;
    // decoded conditions
    wire done_evt;
    wire scan_mode;
    wire one_shot;
    wire last_ch;
    wire cond_ok;
    wire [`APF_HIGH_W-1:0] compared;
    wire store_evt;
    wire irq_ok;
    wire [CH_W-1:0] first_ch;

    // decide whether a value passes the selected condition
    function cond_match;
        input en;
        input cond;
        input [`APF_HIGH_W-1:0] val;
        input [`APF_HIGH_W-1:0] thr;
        begin
            if (!en) begin
                cond_match = 1'b1;
            end else if (cond == `APF_COND_EQ) begin
                cond_match = (val == thr);
            end else begin
                cond_match = (val < thr);
            end
        end
    endfunction

    // first channel of a pass: channel 0 in scan, the selection otherwise
    function [CH_W-1:0] start_chan;
        input scan;
        input [CH_W-1:0] sel;
        begin
            if (scan) begin
                start_chan = {CH_W{1'b0}};
            end else begin
                start_chan = sel;
            end
        end
    endfunction

    // interrupt gate: a compared scan looks at channel 0 only
    function irq_gate;
        input scan;
        input cmp_en;
        input [CH_W-1:0] ch;
        input ok;
        begin
            if (scan && cmp_en) begin
                irq_gate = (ch == {CH_W{1'b0}}) && ok;
            end else begin
                irq_gate = ok;
            end
        end
    endfunction

    // ************************************************************
    // input synchronisers for converter side and pins
    // ************************************************************
    // enable and power bits
    always @(posedge sys_clk) begin
        if (srst) begin
            en_sync1 <= 1'b0;
            en_sync2 <= 1'b0;
            pwr_sync1 <= 1'b0;
            pwr_sync2 <= 1'b0;
        end else begin
            en_sync1 <= converter_enable_bit;
            en_sync2 <= en_sync1;
            pwr_sync1 <= converter_power_bit;
            pwr_sync2 <= pwr_sync1;
        end
    end

    // done strobe and its previous value for the rising edge
    always @(posedge sys_clk) begin
        if (srst) begin
            done_sync1 <= 1'b0;
            done_sync2 <= 1'b0;
            done_prev <= 1'b0;
        end else begin
            done_sync1 <= conv_done;
            done_sync2 <= done_sync1;
            done_prev <= done_sync2;
        end
    end

    // result word; the converter holds it while done is high
    always @(posedge sys_clk) begin
        if (srst) begin
            data_sync1 <= {RES_W{1'b0}};
            data_sync2 <= {RES_W{1'b0}};
        end else begin
            data_sync1 <= conv_data;
            data_sync2 <= data_sync1;
        end
    end

    // ************************************************************
    // mode decode and compare
    // ************************************************************
    assign done_evt = done_sync2 & ~done_prev;
    assign scan_mode = operation_mode_field[0];
    assign one_shot = operation_mode_field[1];
    assign last_ch = scan_mode ? (conv_channel == channel_select_reg) : 1'b1;
    // scan modes compare the high part of channel 0 only
    assign compared = data_sync2[`APF_HIGH_LSB +: `APF_HIGH_W];
    assign cond_ok = cond_match(compare_enable_bit, compare_condition_bit, compared, compare_threshold_reg);
    // a completed conversion that no abort overtook
    assign store_evt = (state == ST_WAIT) && done_evt && !config_write;
    assign irq_ok = irq_gate(scan_mode, compare_enable_bit, conv_channel, cond_ok);
    assign first_ch = start_chan(scan_mode, channel_select_reg);

    // ************************************************************
    // sequencing
    // ************************************************************
    always @* begin
        next_state = state;
        next_channel = conv_channel;
        case (state)
            ST_IDLE: begin
                if (en_sync2 && pwr_sync2) begin
                    next_state = ST_START;
                    next_channel = first_ch;
                end
            end
            ST_START: begin
                next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (config_write) begin
                    next_state = ST_START;
                    next_channel = first_ch;
                end else if (done_evt) begin
                    if (!last_ch) begin
                        next_state = ST_START;
                        next_channel = conv_channel + {{(CH_W-1){1'b0}}, 1'b1};
                    end else if (one_shot) begin
                        next_state = ST_HALT;
                    end else if (en_sync2) begin
                        next_state = ST_START;
                        next_channel = first_ch;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_HALT: begin
                // one-shot finished, wait for enable to drop
                if (!en_sync2) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (!en_sync2 || !pwr_sync2) begin
            next_state = ST_IDLE;
        end
    end

    // ************************************************************
    // state and output registers
    // ************************************************************
    always @(posedge sys_clk) begin
        if (srst) begin
            state <= ST_IDLE;
            conv_channel <= {CH_W{1'b0}};
        end else begin
            state <= next_state;
            conv_channel <= next_channel;
        end
    end

    // start pulse and busy level follow the next state
    always @(posedge sys_clk) begin
        if (srst) begin
            conv_start <= 1'b0;
            busy <= 1'b0;
        end else begin
            conv_start <= (next_state == ST_START);
            busy <= (next_state == ST_START) || (next_state == ST_WAIT);
        end
    end

    // results are stored whether or not the condition holds
    always @(posedge sys_clk) begin
        if (srst) begin
            result_we <= 1'b0;
            result_channel <= {CH_W{1'b0}};
            channel_result_reg <= {RES_W{1'b0}};
            channel0_result_reg <= {RES_W{1'b0}};
        end else begin
            result_we <= 1'b0;
            if (store_evt) begin
                result_we <= 1'b1;
                result_channel <= conv_channel;
                channel_result_reg <= data_sync2;
                if (conv_channel == {CH_W{1'b0}}) begin
                    channel0_result_reg <= data_sync2;
                end
            end
        end
    end

    // interrupt request pulse
    always @(posedge sys_clk) begin
        if (srst) begin
            conv_end_irq <= 1'b0;
        end else begin
            conv_end_irq <= 1'b0;
            if (store_evt && irq_ok) begin
                conv_end_irq <= 1'b1;
            end
        end
    end

    // sticky flag; set wins over a clear in the same cycle
    always @(posedge sys_clk) begin
        if (srst) begin
            conv_end_irq_flag <= 1'b0;
        end else if (conv_end_irq) begin
            conv_end_irq_flag <= 1'b1;
        end else if (flag_clear) begin
            conv_end_irq_flag <= 1'b0;
        end
    end

endmodule // apf_compare

/* verification/apf_compare_sva.sv */
`timescale 1ns/1ps
`include "apf_regs.vh"
module apf_compare_sva #(
    parameter RES_W = `APF_RES_W,
    parameter CH_W = `APF_CH_W
) (
    input wire sys_clk,
    input wire srst,
    input wire converter_enable_bit,
    input wire converter_power_bit,
    input wire [1:0] operation_mode_field,
    input wire [CH_W-1:0] channel_select_reg,
    input wire compare_enable_bit,
    input wire compare_condition_bit,
    input wire [`APF_HIGH_W-1:0] compare_threshold_reg,
    input wire config_write,
    input wire flag_clear,
    input wire conv_start,
    input wire [CH_W-1:0] conv_channel,
    input wire result_we,
    input wire [CH_W-1:0] result_channel,
    input wire [RES_W-1:0] channel_result_reg,
    input wire [RES_W-1:0] channel0_result_reg,
    input wire conv_end_irq,
    input wire conv_end_irq_flag
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // ************************************************************
    // store, compare and restart checks
    // ************************************************************
    // compared store: select modes, or channel 0 of a scan
    wire run = converter_enable_bit && converter_power_bit;
    wire last = result_we && result_channel == channel_select_reg;
    wire cmp = result_we && compare_enable_bit && (!operation_mode_field[0] || result_channel == 0);
    wire [`APF_HIGH_W-1:0] hi = channel_result_reg[`APF_HIGH_LSB +: `APF_HIGH_W];
    flag_set_a: assert property (conv_end_irq |=> conv_end_irq_flag && !conv_end_irq)
        else $error("irq not a pulse or flag not set");
    flag_keep_a: assert property (conv_end_irq_flag && !flag_clear |=> conv_end_irq_flag)
        else $error("flag lost without clear");
    plain_irq_a: assert property (last && !compare_enable_bit |-> conv_end_irq)
        else $error("irq missing with compare off");
    eq_irq_a: assert property (cmp && !compare_condition_bit |-> conv_end_irq == (hi == compare_threshold_reg))
        else $error("equal compare wrong");
    lt_irq_a: assert property (cmp && compare_condition_bit |-> conv_end_irq == (hi < compare_threshold_reg))
        else $error("less-than compare wrong");
    scan_gate_a: assert property (result_we && compare_enable_bit && operation_mode_field[0] && result_channel != 0
        |-> !conv_end_irq)
        else $error("later scan channel raised irq");
    ch0_copy_a: assert property (result_we && result_channel == 0 |-> channel0_result_reg == channel_result_reg)
        else $error("channel 0 result not kept");
    restart_a: assert property (last && run && operation_mode_field == `APF_MODE_CONT_SEL
        |-> conv_start && conv_channel == channel_select_reg)
        else $error("no restart in continuous select");
    wrap_a: assert property (last && run && operation_mode_field == `APF_MODE_CONT_SCAN
        |-> conv_start && conv_channel == 0)
        else $error("scan did not wrap to channel 0");
    halt_a: assert property (last && operation_mode_field[1] |-> !conv_start [*8])
        else $error("one-shot did not halt");
    cover property (conv_end_irq && compare_condition_bit);
    cover property (last && operation_mode_field == `APF_MODE_CONT_SCAN);
    cover property (conv_end_irq_flag && config_write);
endmodule // apf_compare_sva
bind apf_compare apf_compare_sva #(.RES_W(RES_W), .CH_W(CH_W)) chk_i (.*);

/* verification/apf_conv_model.sv */
`timescale 1ns/1ps
`include "apf_regs.vh"
module apf_conv_model (
    input wire sys_clk,
    input wire conv_start,
    input wire [`APF_CH_W-1:0] conv_channel,
    input wire slow,
    input wire [`APF_RES_W-1:0] ch0_val,
    input wire [`APF_RES_W-1:0] other_val,
    output reg conv_done = 1'b0,
    output reg [`APF_RES_W-1:0] conv_data = 10'h155
);
    reg [`APF_CH_W-1:0] ch = 5'h0;
    reg [5:0] cnt = 6'h0;
    reg [1:0] hold = 2'h0;
    // ************************************************************
    // converter: a start outside the done hold restarts it, data scrambled once released
    // ************************************************************
    always @(posedge sys_clk) begin
        if (hold != 2'h0) begin
            hold <= hold - 2'h1;
            if (hold == 2'h1) begin
                conv_done <= 1'b0;
                conv_data <= ~conv_data;
            end
        end else if (conv_start === 1'b1) begin
            ch <= conv_channel;
            cnt <= slow ? 6'h1e : 6'h05;
        end else if (cnt != 6'h0) begin
            cnt <= cnt - 6'h1;
            if (cnt == 6'h1) begin
                conv_data <= (ch == 5'h0) ? ch0_val : other_val;
                conv_done <= 1'b1;
                hold <= 2'h2;
            end
        end
    end
endmodule // apf_conv_model

/* verification/testbench.sv */
`timescale 1ns/1ps
`include "apf_regs.vh"
module testbench;
    reg sys_clk, srst, converter_enable_bit, converter_power_bit, compare_enable_bit, compare_condition_bit;
    reg config_write, flag_clear, slow;
    reg [1:0] operation_mode_field;
    reg [4:0] channel_select_reg, pos;
    reg [7:0] compare_threshold_reg;
    reg [9:0] ch0_val, other_val;
    wire conv_done, conv_start, busy, result_we, conv_end_irq, conv_end_irq_flag;
    wire [4:0] conv_channel, result_channel;
    wire [9:0] conv_data, channel_result_reg, channel0_result_reg;
    integer bad_count, n_checks, nwe, nirq, w0, i0, k;
    apf_compare dut (.*);
    apf_conv_model model (.*);
    // ************************************************************
    // clock, compare, verdict and store monitor
    // ************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task chk(input [95:0] s, input [31:0] e, input [31:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0s expected %h seen %h", s, e, g);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", n_checks, bad_count);
            if (bad_count == 0 && n_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // counts stores and irqs, follows the scan order
    always @(posedge sys_clk) begin
        if (result_we === 1'b1) begin
            nwe <= nwe + 1;
            nirq <= nirq + (conv_end_irq === 1'b1);
            if (operation_mode_field[0]) begin
                chk("scan_chan", {27'h0, pos}, {27'h0, result_channel});
                pos <= (pos == channel_select_reg) ? 5'h0 : pos + 5'h1;
            end
        end
    end
    // one run: set up, wait for n stores, stop, clear the flag
    task run(input [1:0] m, input [4:0] s, input c, input d, input [7:0] t, input [9:0] a, input [4:0] n,
        input [4:0] ei);
        begin
            @(negedge sys_clk);
            {operation_mode_field, channel_select_reg, compare_enable_bit, compare_condition_bit} = {m, s, c, d};
            compare_threshold_reg = t;
            ch0_val = a;
            pos = 5'h0;
            w0 = nwe;
            i0 = nirq;
            converter_enable_bit = 1'b1;
            converter_power_bit = 1'b1;
            for (k = 0; k < 900 && nwe - w0 < n; k = k + 1)
                @(negedge sys_clk);
            chk("stores", n, nwe - w0);
            chk("irqs", ei, nirq - i0);
            chk("result", other_val, channel_result_reg);
            if (m[0])
                chk("ch0_result", a, channel0_result_reg);
            if (!m[1]) begin
                pos = 5'h0;
                config_write = 1'b1;
                @(negedge sys_clk);
                config_write = 1'b0;
                for (k = 0; k < 900 && nwe - w0 < n + 1; k = k + 1)
                    @(negedge sys_clk);
                chk("abort_store", n + 1, nwe - w0);
            end
            if (m[1]) begin
                repeat (60) @(negedge sys_clk);
                chk("halt", n, nwe - w0);
                config_write = 1'b1;
                @(negedge sys_clk);
                config_write = 1'b0;
                chk("flag_kept", 1, conv_end_irq_flag);
            end
            chk("busy", !m[1], busy);
            converter_enable_bit = 1'b0;
            converter_power_bit = 1'b0;
            repeat (40) @(negedge sys_clk);
            chk("idle_busy", 0, busy);
            flag_clear = 1'b1;
            @(negedge sys_clk);
            flag_clear = 1'b0;
            chk("flag_clr", 0, conv_end_irq_flag);
            $display("test mode %0d done", m);
        end
    endtask
    initial begin
        {srst, converter_enable_bit, converter_power_bit, compare_enable_bit, compare_condition_bit} = 5'h10;
        {config_write, flag_clear, slow} = 3'h0;
        {operation_mode_field, channel_select_reg, compare_threshold_reg, ch0_val, pos} = 30'h0;
        other_val = 10'h2a5;
        {bad_count, n_checks, nwe, nirq} = 128'h0;
        repeat (5) @(negedge sys_clk);
        srst = 1'b0;
        run(`APF_MODE_CONT_SEL, 5'h3, 0, 0, 8'h00, 10'h0, 3, 3);
        run(`APF_MODE_CONT_SEL, 5'h3, 1, `APF_COND_EQ, 8'ha9, 10'h0, 2, 2);
        run(`APF_MODE_CONT_SEL, 5'h3, 1, `APF_COND_EQ, 8'haa, 10'h0, 2, 0);
        run(`APF_MODE_CONT_SEL, 5'h3, 1, `APF_COND_LT, 8'haa, 10'h0, 2, 2);
        run(`APF_MODE_CONT_SEL, 5'h3, 1, `APF_COND_LT, 8'ha9, 10'h0, 2, 0);
        slow = 1'b1;
        run(`APF_MODE_CONT_SCAN, 5'h2, 1, `APF_COND_EQ, 8'h3f, 10'h0fc, 6, 2);
        run(`APF_MODE_CONT_SCAN, 5'h2, 1, `APF_COND_EQ, 8'ha9, 10'h0fc, 6, 0);
        run(`APF_MODE_CONT_SCAN, 5'h2, 0, 0, 8'h00, 10'h0fc, 3, 3);
        slow = 1'b0;
        run(`APF_MODE_ONE_SEL, 5'h3, 1, `APF_COND_LT, 8'haa, 10'h0, 1, 1);
        run(`APF_MODE_ONE_SCAN, 5'h3, 1, `APF_COND_EQ, 8'h3f, 10'h0fc, 4, 1);
        conclude;
    end
    // watchdog well beyond the expected run length
    initial begin
        #200000;
        bad_count = bad_count + 1;
        conclude;
    end
endmodule // testbench
